/* File: iscr_pkg.sv */
package iscr_pkg;

    // Widths of the pixel array coordinates, pixel samples and the output port.
    localparam int COORD_W = 11;
    localparam int PIX_W = 10;
    localparam int DATA_W = 8;
    localparam int GPIO_N = 5;
    localparam int OTP_BYTES = 2;
    localparam int OTP_W = 16;
    localparam int CNT_W = 12;
    localparam int BLANK_W = 8;

    // Master clock rate and the times derived from it.
    localparam int MCLK_KHZ = 40000;
    localparam int OTP_PROG_US = 100;
    localparam int FLASH_US = 50;
    localparam int SHUTTER_US = 20;
    localparam logic [CNT_W-1:0] OTP_PROG_CYC = CNT_W'((OTP_PROG_US * MCLK_KHZ) / 1000);
    localparam logic [CNT_W-1:0] FLASH_CYC = CNT_W'((FLASH_US * MCLK_KHZ) / 1000);
    localparam logic [CNT_W-1:0] SHUTTER_CYC = CNT_W'((SHUTTER_US * MCLK_KHZ) / 1000);

    // Blanking lengths in link clock cycles.
    localparam logic [BLANK_W-1:0] HBLANK_CYC = 8'h10;
    localparam logic [BLANK_W-1:0] VBLANK_CYC = 8'h40;

    // Readout step sizes.
    localparam logic [COORD_W-1:0] STEP_ONE = 11'h001;
    localparam logic [COORD_W-1:0] STEP_TWO = 11'h002;

    // General purpose pin positions with alternate functions.
    localparam int GPIO_LSB0 = 0;
    localparam int GPIO_LSB1 = 1;
    localparam int GPIO_OE = 2;
    localparam int GPIO_STROBE = 4;

    // Functions of general purpose pin four.
    localparam logic [1:0] G4_PLAIN = 2'h0;
    localparam logic [1:0] G4_FLASH = 2'h1;
    localparam logic [1:0] G4_SHUTTER = 2'h2;

    typedef struct packed {
        logic [COORD_W-1:0] col_start;
        logic [COORD_W-1:0] col_end;
        logic [COORD_W-1:0] row_start;
        logic [COORD_W-1:0] row_end;
    } iscr_win_t;

    typedef struct packed {
        logic mirror;
        logic flip;
        logic skip_h;
        logic skip_v;
        logic avg_h;
        logic avg_v;
    } iscr_mode_t;

    typedef struct packed {
        iscr_win_t win;
        iscr_mode_t mode;
    } iscr_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_VBLANK = 4'h2,
        ST_LINE = 4'h4,
        ST_HBLANK = 4'h8
    } iscr_state_t;

endpackage

/* File: iscr_sync2.sv */
`timescale 1ns/1ps
module iscr_sync2
    import iscr_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // Two flip-flop synchroniser; only the second stage is visible outside.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

/* File: iscr_readout_top.sv */
`timescale 1ns/1ps
// Contract
// - Standby pin high stops readout; low lets the sensor run normally.
// - Master reset is active low and holds all logic reset while low.
// - Eight-bit pixel data with pixel clock, line and frame qualifiers.
// - Output size follows column and row window bounds; binning shrinks it.
// - Mirror reads each row from column end back to column start.
// - Flip reads rows from row end back to row start.
// - Skipping and averaging work independently per direction.
// - Subsampling handles every second row and column.
// - Each general purpose pin works as register-controlled input or output.
// - Pin levels are caught after reset as a module identifier.
// - Pins one and zero can carry the two raw data LSBs.
// - Pin four can emit a flash or shutter pulse.
// - Pin two can serve as active-low output enable for pixel data.
// - Pixel port switches asynchronously with pin two; the register enable switches it one master clock later.
// - Two-byte one-time store holds module identification.
// - Completion bit shows programming finished; host then verifies by read.
module iscr_readout_top
    import iscr_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic standby,
    input wire logic link_clk,
    input wire iscr_cfg_t cfg,
    input wire logic port_en,
    input wire logic oe_reg,
    input wire logic oe_pin_en,
    input wire logic [PIX_W-1:0] arr_pix_a,
    input wire logic [PIX_W-1:0] arr_pix_b,
    output logic [COORD_W-1:0] arr_col,
    output logic [COORD_W-1:0] arr_row,
    output logic [DATA_W-1:0] pix_data,
    output logic pix_oe,
    output logic pixel_clk,
    output logic line_valid,
    output logic frame_valid,
    input wire logic [GPIO_N-1:0] gpio_in,
    output logic [GPIO_N-1:0] gpio_out,
    output logic [GPIO_N-1:0] gpio_oe,
    input wire logic [GPIO_N-1:0] gpio_dir,
    input wire logic [GPIO_N-1:0] gpio_val,
    input wire logic gpio_in_en,
    input wire logic raw10_en,
    input wire logic [1:0] gpio4_func,
    output logic [GPIO_N-1:0] gpio_state,
    output logic [GPIO_N-1:0] module_id,
    input wire logic prog_write,
    input wire logic prog_arm,
    input wire logic [OTP_W-1:0] prog_value,
    output logic prog_busy,
    output logic prog_done,
    output logic [OTP_W-1:0] otp_data
);

    function automatic logic [COORD_W-1:0] step_pos(input logic [COORD_W-1:0] pos, input logic rev,
                                                     input logic two);
        logic [COORD_W-1:0] d;
        d = two ? STEP_TWO : STEP_ONE;
        step_pos = rev ? pos - d : pos + d;
    endfunction

    function automatic logic [COORD_W-1:0] span_of(input logic [COORD_W-1:0] lo, input logic [COORD_W-1:0] hi,
                                                    input logic two);
        logic [COORD_W-1:0] s;
        s = hi - lo;
        span_of = two ? (s >> 1) : s;
    endfunction

    logic [1:0] rst_m_r;
    logic [1:0] rst_l_r;
    logic rst_n_m;
    logic rst_n_l;
    logic stby_s;
    logic stby_l;
    logic [GPIO_N-1:0] gpio_s;
    logic req_l;
    logic ack_s;
    logic fs_s;

    // Reset is taken asynchronously and released through two flops per domain.
    // reset release
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rst_m_r <= 2'h0;
        else
            rst_m_r <= {rst_m_r[0], 1'b1};
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_l_r <= 2'h0;
        else
            rst_l_r <= {rst_l_r[0], 1'b1};
    end
    assign rst_n_m = rst_m_r[1];
    assign rst_n_l = rst_l_r[1];

    // Mclk side: configuration hold register, handshake, pins, strobe and store.
    iscr_cfg_t cfg_hold_r, cfg_hold_nxt;
    logic req_r, req_nxt, fs_d_r, fs_d_nxt, id_taken_r, id_taken_nxt, prog_busy_r, prog_busy_nxt;
    logic [1:0] id_wait_r, id_wait_nxt;
    logic prog_done_r, prog_done_nxt;
    logic [CNT_W-1:0] strobe_cnt_r, strobe_cnt_nxt, prog_cnt_r, prog_cnt_nxt;
    logic [GPIO_N-1:0] module_id_r, module_id_nxt, gpio_state_r, gpio_state_nxt, gpio_hi_r, gpio_hi_nxt;
    logic [GPIO_N-1:0] gpio_oe_r, gpio_oe_nxt;
    logic [OTP_W-1:0] prog_data_r, prog_data_nxt;
    logic [7:0] otp_mem_r [OTP_BYTES];
    logic [7:0] otp_mem_nxt [OTP_BYTES];
    logic port_on_r, port_on_nxt;

    iscr_sync2 #(.W(1)) u_sync_stby (.clk(mclk), .rst_n(rst_n_m), .din(standby), .dout(stby_s));
    iscr_sync2 #(.W(GPIO_N)) u_sync_gpio (.clk(mclk), .rst_n(rst_n_m), .din(gpio_in), .dout(gpio_s));

    // Next values for the mclk domain.
    always_comb
    begin
        cfg_hold_nxt = cfg_hold_r;
        req_nxt = req_r;
        fs_d_nxt = fs_s;
        strobe_cnt_nxt = (strobe_cnt_r != '0) ? strobe_cnt_r - 1'b1 : strobe_cnt_r;
        id_wait_nxt = {id_wait_r[0], 1'b1};
        id_taken_nxt = id_taken_r | id_wait_r[1];
        module_id_nxt = module_id_r;
        gpio_hi_nxt = gpio_val;
        gpio_oe_nxt = gpio_dir;
        prog_busy_nxt = prog_busy_r;
        prog_done_nxt = prog_done_r;
        prog_cnt_nxt = prog_cnt_r;
        prog_data_nxt = prog_data_r;
        otp_mem_nxt = otp_mem_r;
        port_on_nxt = port_en & oe_reg;
        // The hold register only reloads once the link side has taken the last copy.
        if (req_r == ack_s)
        begin
            cfg_hold_nxt = cfg;
            req_nxt = ~req_r;
        end
        // module identifier capture
        // The pin synchroniser restarts with reset, so the capture waits until it holds real levels.
        if (!id_taken_r && id_wait_r[1])
            module_id_nxt = gpio_s;
        gpio_state_nxt = gpio_in_en ? gpio_s : '0;
        if ((fs_s != fs_d_r) && (gpio4_func == G4_FLASH))
            strobe_cnt_nxt = FLASH_CYC;
        else if ((fs_s != fs_d_r) && (gpio4_func == G4_SHUTTER))
            strobe_cnt_nxt = SHUTTER_CYC;
        if (gpio4_func != G4_PLAIN)
        begin
            gpio_hi_nxt[GPIO_STROBE] = (strobe_cnt_nxt != '0);
            gpio_oe_nxt[GPIO_STROBE] = 1'b1;
        end
        if (oe_pin_en)
            gpio_oe_nxt[GPIO_OE] = 1'b0;
        if (raw10_en)
        begin
            gpio_oe_nxt[GPIO_LSB0] = port_en;
            gpio_oe_nxt[GPIO_LSB1] = port_en;
        end
        if (prog_write && !prog_arm)
        begin
            prog_data_nxt = prog_value;
            prog_done_nxt = 1'b0;
        end
        else if (prog_write && prog_arm && stby_s && !prog_busy_r)
        begin
            prog_busy_nxt = 1'b1;
            prog_cnt_nxt = OTP_PROG_CYC - 1'b1;
        end
        if (prog_busy_r)
        begin
            prog_cnt_nxt = prog_cnt_r - 1'b1;
            if (prog_cnt_r == '0)
            begin
                for (int i = 0; i < OTP_BYTES; i++)
                    otp_mem_nxt[i] = otp_mem_r[i] | prog_data_r[8*i +: 8];
                prog_busy_nxt = 1'b0;
                prog_done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n_m)
    begin
        if (!rst_n_m)
        begin
            cfg_hold_r <= '0;
            req_r <= 1'b0;
            fs_d_r <= 1'b0;
            strobe_cnt_r <= '0;
            id_taken_r <= 1'b0;
            id_wait_r <= '0;
            module_id_r <= '0;
            gpio_state_r <= '0;
            gpio_hi_r <= '0;
            gpio_oe_r <= '0;
            prog_busy_r <= 1'b0;
            prog_done_r <= 1'b0;
            prog_cnt_r <= '0;
            prog_data_r <= '0;
            otp_mem_r <= '{default: '0};
            port_on_r <= 1'b0;
        end
        else
        begin
            cfg_hold_r <= cfg_hold_nxt;
            req_r <= req_nxt;
            fs_d_r <= fs_d_nxt;
            strobe_cnt_r <= strobe_cnt_nxt;
            id_taken_r <= id_taken_nxt;
            id_wait_r <= id_wait_nxt;
            module_id_r <= module_id_nxt;
            gpio_state_r <= gpio_state_nxt;
            gpio_hi_r <= gpio_hi_nxt;
            gpio_oe_r <= gpio_oe_nxt;
            prog_busy_r <= prog_busy_nxt;
            prog_done_r <= prog_done_nxt;
            prog_cnt_r <= prog_cnt_nxt;
            prog_data_r <= prog_data_nxt;
            otp_mem_r <= otp_mem_nxt;
            port_on_r <= port_on_nxt;
        end
    end

    // Link side: readout sequencer clocked by the pixel source clock.
    iscr_state_t state_r, state_nxt;
    iscr_cfg_t cfg_sh_r, cfg_sh_nxt, cfg_act_r, cfg_act_nxt, c;
    logic ack_l_r, ack_l_nxt, fs_tog_r, fs_tog_nxt, pclk_r, pclk_nxt, lv_r, lv_nxt, fv_r, fv_nxt;
    logic raw10_l_r, raw10_l_nxt;
    logic raw10_l;
    logic [COORD_W-1:0] col_r, col_nxt, row_r, row_nxt, col_left_r, col_left_nxt, row_left_r, row_left_nxt;
    logic [COORD_W-1:0] acol_r, acol_nxt, arow_r, arow_nxt;
    logic [BLANK_W-1:0] blank_r, blank_nxt;
    logic [PIX_W-1:0] first_r, first_nxt, vval, hval;
    logic [PIX_W:0] vsum, hsum;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic [1:0] lsb_r, lsb_nxt;
    logic hstep2, vstep2;

    iscr_sync2 #(.W(1)) u_sync_req (.clk(link_clk), .rst_n(rst_n_l), .din(req_r), .dout(req_l));
    iscr_sync2 #(.W(1)) u_sync_lstby (.clk(link_clk), .rst_n(rst_n_l), .din(stby_s), .dout(stby_l));
    iscr_sync2 #(.W(1)) u_sync_raw10 (.clk(link_clk), .rst_n(rst_n_l), .din(raw10_en), .dout(raw10_l));

    // Return paths of the handshake and the frame start toggle into the mclk domain.
    iscr_sync2 #(.W(1)) u_sync_ack (.clk(mclk), .rst_n(rst_n_m), .din(ack_l_r), .dout(ack_s));
    iscr_sync2 #(.W(1)) u_sync_fs (.clk(mclk), .rst_n(rst_n_m), .din(fs_tog_r), .dout(fs_s));

    // Pixel value with optional vertical then horizontal averaging.
    // averaging paths
    always_comb
    begin
        vsum = {1'b0, arr_pix_a} + {1'b0, arr_pix_b};
        vval = cfg_act_r.mode.avg_v ? vsum[PIX_W:1] : arr_pix_a;
        hsum = {1'b0, first_r} + {1'b0, vval};
        hval = cfg_act_r.mode.avg_h ? hsum[PIX_W:1] : first_r;
    end

    // Next values for the link domain.
    always_comb
    begin
        state_nxt = state_r;
        cfg_sh_nxt = cfg_sh_r;
        cfg_act_nxt = cfg_act_r;
        ack_l_nxt = ack_l_r;
        fs_tog_nxt = fs_tog_r;
        lv_nxt = lv_r;
        fv_nxt = fv_r;
        raw10_l_nxt = raw10_l;
        col_nxt = col_r;
        row_nxt = row_r;
        col_left_nxt = col_left_r;
        row_left_nxt = row_left_r;
        acol_nxt = acol_r;
        arow_nxt = arow_r;
        blank_nxt = (blank_r != '0) ? blank_r - 1'b1 : blank_r;
        first_nxt = first_r;
        data_nxt = data_r;
        lsb_nxt = lsb_r;
        // The hold register is stable while the request is outstanding.
        if (req_l != ack_l_r)
        begin
            cfg_sh_nxt = cfg_hold_r;
            ack_l_nxt = req_l;
        end
        c = (state_r == ST_VBLANK) ? cfg_sh_r : cfg_act_r;
        hstep2 = c.mode.skip_h | c.mode.avg_h;
        vstep2 = c.mode.skip_v | c.mode.avg_v;
        if (pclk_r)
            lv_nxt = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                fv_nxt = 1'b0;
                if (!stby_l)
                begin
                    state_nxt = ST_VBLANK;
                    blank_nxt = VBLANK_CYC;
                end
            end
            ST_VBLANK:
            begin
                // The frame qualifier falls with the line qualifier, so the last pixel stays inside the frame.
                if (pclk_r)
                    fv_nxt = 1'b0;
                if (stby_l && !fv_r)
                    state_nxt = ST_IDLE;
                else if (!stby_l && pclk_r && (blank_r == '0))
                begin
                    cfg_act_nxt = cfg_sh_r;
                    row_nxt = c.mode.flip ? c.win.row_end : c.win.row_start;
                    row_left_nxt = span_of(c.win.row_start, c.win.row_end, vstep2);
                    fv_nxt = 1'b1;
                    fs_tog_nxt = ~fs_tog_r;
                    state_nxt = ST_LINE;
                end
            end
            ST_LINE:
            begin
                if (!pclk_r)
                begin
                    first_nxt = vval;
                    acol_nxt = step_pos(col_r, c.mode.mirror, 1'b0);
                end
                else
                begin
                    lv_nxt = 1'b1;
                    data_nxt = hval[PIX_W-1:PIX_W-DATA_W];
                    lsb_nxt = hval[1:0];
                    col_nxt = step_pos(col_r, c.mode.mirror, hstep2);
                    col_left_nxt = col_left_r - 1'b1;
                    acol_nxt = col_nxt;
                    if (col_left_r == '0)
                    begin
                        row_nxt = step_pos(row_r, c.mode.flip, vstep2);
                        row_left_nxt = row_left_r - 1'b1;
                        blank_nxt = (row_left_r == '0) ? VBLANK_CYC : HBLANK_CYC;
                        state_nxt = (row_left_r == '0) ? ST_VBLANK : ST_HBLANK;
                    end
                end
            end
            ST_HBLANK:
            begin
                if (pclk_r && (blank_r == '0))
                    state_nxt = ST_LINE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        if ((state_nxt == ST_LINE) && (state_r != ST_LINE))
        begin
            col_nxt = c.mode.mirror ? c.win.col_end : c.win.col_start;
            col_left_nxt = span_of(c.win.col_start, c.win.col_end, hstep2);
            acol_nxt = col_nxt;
            arow_nxt = row_nxt;
        end
        pclk_nxt = (state_nxt == ST_IDLE) ? 1'b0 : ~pclk_r;
    end

    always_ff @(posedge link_clk or negedge rst_n_l)
    begin
        if (!rst_n_l)
        begin
            state_r <= ST_IDLE;
            cfg_sh_r <= '0;
            cfg_act_r <= '0;
            ack_l_r <= 1'b0;
            fs_tog_r <= 1'b0;
            pclk_r <= 1'b0;
            lv_r <= 1'b0;
            fv_r <= 1'b0;
            raw10_l_r <= 1'b0;
            col_r <= '0;
            row_r <= '0;
            col_left_r <= '0;
            row_left_r <= '0;
            acol_r <= '0;
            arow_r <= '0;
            blank_r <= '0;
            first_r <= '0;
            data_r <= '0;
            lsb_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cfg_sh_r <= cfg_sh_nxt;
            cfg_act_r <= cfg_act_nxt;
            ack_l_r <= ack_l_nxt;
            fs_tog_r <= fs_tog_nxt;
            pclk_r <= pclk_nxt;
            lv_r <= lv_nxt;
            fv_r <= fv_nxt;
            raw10_l_r <= raw10_l_nxt;
            col_r <= col_nxt;
            row_r <= row_nxt;
            col_left_r <= col_left_nxt;
            row_left_r <= row_left_nxt;
            acol_r <= acol_nxt;
            arow_r <= arow_nxt;
            blank_r <= blank_nxt;
            first_r <= first_nxt;
            data_r <= data_nxt;
            lsb_r <= lsb_nxt;
        end
    end

    // Outputs; the enable gate is asynchronous to follow the pin without a clock.
    // asynchronous enable
    assign pix_oe = port_en & (oe_pin_en ? ~gpio_in[GPIO_OE] : port_on_r);
    assign gpio_out = {gpio_hi_r[GPIO_N-1:2], raw10_l_r ? lsb_r : gpio_hi_r[1:0]};
    assign gpio_oe = gpio_oe_r;
    assign arr_col = acol_r;
    assign arr_row = arow_r;
    assign pix_data = data_r;
    assign pixel_clk = pclk_r;
    assign line_valid = lv_r;
    assign frame_valid = fv_r;
    assign gpio_state = gpio_state_r;
    assign module_id = module_id_r;
    assign prog_busy = prog_busy_r;
    assign prog_done = prog_done_r;
    assign otp_data = {otp_mem_r[1], otp_mem_r[0]};

    stby_idle_a: assert property (@(posedge link_clk) disable iff (!rst_n_l)
        (stby_l && (state_r == ST_IDLE)) |=> (state_r == ST_IDLE) && !fv_r) else $error("Readout left standby.");
    reset_hold_a: assert property (@(posedge mclk)
        !rst_n_m |-> (!prog_busy_r && (strobe_cnt_r == '0))) else $error("State active in reset.");
    line_in_frame_a: assert property (@(posedge link_clk) disable iff (!rst_n_l)
        lv_r |-> fv_r) else $error("Line qualifier outside frame.");
    data_stable_a: assert property (@(posedge link_clk) disable iff (!rst_n_l)
        (!pclk_r ##1 pclk_r) |-> $stable(data_r) && $stable(lv_r)) else $error("Data moved at rising edge.");
    mirror_order_a: assert property (@(posedge link_clk) disable iff (!rst_n_l)
        (state_r == ST_LINE && pclk_r && col_left_r != '0 && cfg_act_r.mode.mirror)
        |=> col_r == $past(col_r) - (cfg_act_r.mode.skip_h | cfg_act_r.mode.avg_h ? STEP_TWO : STEP_ONE))
        else $error("Mirror column order wrong.");
    flip_order_a: assert property (@(posedge link_clk) disable iff (!rst_n_l)
        (state_r == ST_LINE && pclk_r && col_left_r == '0 && row_left_r != '0 && cfg_act_r.mode.flip)
        |=> row_r == $past(row_r) - (cfg_act_r.mode.skip_v | cfg_act_r.mode.avg_v ? STEP_TWO : STEP_ONE))
        else $error("Flip row order wrong.");
    strobe_len_a: assert property (@(posedge mclk) disable iff (!rst_n_m)
        $rose(strobe_cnt_r != '0) |-> (strobe_cnt_r == FLASH_CYC || strobe_cnt_r == SHUTTER_CYC))
        else $error("Strobe length wrong.");
    prog_done_a: assert property (@(posedge mclk) disable iff (!rst_n_m)
        $rose(prog_done_r) |-> $past(prog_busy_r) && !prog_busy_r) else $error("Done without programming.");
    prog_stby_a: assert property (@(posedge mclk) disable iff (!rst_n_m)
        $rose(prog_busy_r) |-> $past(stby_s) && $past(prog_write)) else $error("Programming outside standby.");

endmodule

/* File: iscr_host_model.sv */
`timescale 1ns/1ps
// Host capture side: counts the bytes of the latest frame and keeps its first and last byte.
module iscr_host_model
    import iscr_pkg::*;
(
    input wire logic pixel_clk,
    input wire logic line_valid,
    input wire logic frame_valid,
    input wire logic [DATA_W-1:0] pix_data,
    output int cnt,
    output logic [DATA_W-1:0] first_b,
    output logic [DATA_W-1:0] last_b
);
    logic fv_r = 1'b0;
    // qualified byte capture
    // Bytes count only at a rising pixel clock inside both qualifiers.
    always @(posedge pixel_clk)
    begin
        fv_r <= frame_valid;
        if (frame_valid && !fv_r)
            cnt <= 0;
        else if (frame_valid && line_valid)
        begin
            if (cnt == 0)
                first_b <= pix_data;
            last_b <= pix_data;
            cnt <= cnt + 1;
        end
    end
endmodule

/* File: image_sensor_readout_control_bench.sv */
`timescale 1ns/1ps
module image_sensor_readout_control_bench
    import iscr_pkg::*;
();
    typedef struct { iscr_mode_t m; int n; logic [7:0] f; logic [7:0] l; } iscr_row_t;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic standby = 1'b0;
    iscr_cfg_t cfg = '{'{11'h00a, 11'h014, 11'h004, 11'h005}, 6'h00};
    logic port_en = 1'b1;
    logic oe_reg = 1'b0;
    logic oe_pin_en = 1'b0;
    logic [GPIO_N-1:0] gpio_in = 5'h11;
    logic [GPIO_N-1:0] gpio_dir = 5'h03;
    logic [GPIO_N-1:0] gpio_val = 5'h02;
    logic gpio_in_en = 1'b1;
    logic raw10_en = 1'b0;
    logic [1:0] gpio4_func = G4_PLAIN;
    logic prog_write = 1'b0;
    logic prog_arm = 1'b0;
    logic [OTP_W-1:0] prog_value = 16'h0000;
    logic [PIX_W-1:0] arr_pix_a, arr_pix_b;
    logic [COORD_W-1:0] arr_col, arr_row;
    logic [DATA_W-1:0] pix_data, first_b, last_b;
    logic pix_oe, pixel_clk, line_valid, frame_valid, prog_busy, prog_done;
    logic [GPIO_N-1:0] gpio_out, gpio_oe, gpio_state, module_id;
    logic [OTP_W-1:0] otp_data;
    int cnt, errors, n_tests, i, k;
    // Expected counts and bytes of one frame over columns 10 to 20 and rows 4 to 5.
    iscr_row_t rows [7] = '{
        '{6'h00, 22, 8'h0a, 8'h54},
        '{6'h20, 22, 8'h14, 8'h4a},
        '{6'h10, 22, 8'h4a, 8'h14},
        '{6'h08, 12, 8'h0a, 8'h54},
        '{6'h04, 11, 8'h0a, 8'h14},
        '{6'h02, 12, 8'h0a, 8'h54},
        '{6'h01, 11, 8'h2a, 8'h34}};

    // The array model puts the row and column into the upper eight pixel bits.
    assign arr_pix_a = {arr_row[1:0], arr_col[5:0], 2'h0};
    assign arr_pix_b = {arr_row[1:0] + 2'h1, arr_col[5:0], 2'h0};

    // Clocks: the link clock is offset so that its edges never meet the master clock.
    // master clock rate
    always #12.5 mclk = ~mclk;
    initial
    begin
        #3;
        forever #40 link_clk = ~link_clk;
    end

    iscr_readout_top iscr_readout_top_inst (.mclk(mclk), .reset_n(reset_n), .standby(standby),
        .link_clk(link_clk), .cfg(cfg), .port_en(port_en), .oe_reg(oe_reg), .oe_pin_en(oe_pin_en),
        .arr_pix_a(arr_pix_a), .arr_pix_b(arr_pix_b), .arr_col(arr_col), .arr_row(arr_row),
        .pix_data(pix_data), .pix_oe(pix_oe), .pixel_clk(pixel_clk), .line_valid(line_valid),
        .frame_valid(frame_valid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_dir(gpio_dir), .gpio_val(gpio_val), .gpio_in_en(gpio_in_en), .raw10_en(raw10_en),
        .gpio4_func(gpio4_func), .gpio_state(gpio_state), .module_id(module_id),
        .prog_write(prog_write), .prog_arm(prog_arm), .prog_value(prog_value),
        .prog_busy(prog_busy), .prog_done(prog_done), .otp_data(otp_data));

    iscr_host_model iscr_host_model_inst (.pixel_clk(pixel_clk), .line_valid(line_valid),
        .frame_valid(frame_valid), .pix_data(pix_data), .cnt(cnt), .first_b(first_b), .last_b(last_b));

    // Compares one value and reports a mismatch at once.
    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Waits a bounded time for the frame qualifier to reach a level.
    task wait_fv(input logic lvl);
        k = 0;
        while (frame_valid !== lvl && k < 20000)
        begin
            @(posedge mclk);
            k++;
        end
        chk(16'(frame_valid === lvl), 16'h0001, "frame qualifier wait");
    endtask

    // Issues one write to program control.
    task prog(input logic arm);
        @(posedge mclk);
        prog_write <= 1'b1;
        prog_arm <= arm;
        @(posedge mclk);
        prog_write <= 1'b0;
    endtask

    task finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    initial
    begin
        #1000000;
        errors++;
        finish_test();
    end

    initial
    begin
        repeat (16) @(posedge mclk);
        chk(16'({frame_valid, prog_busy, gpio_out}), 16'h0000, "outputs in reset");
        reset_n <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(16'(module_id), 16'h0011, "module id");
        chk(16'(gpio_state), 16'h0011, "input readback");
        chk(16'({gpio_oe, gpio_out[1:0]}), 16'h000e, "plain outputs");
        oe_reg <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(16'(pix_oe), 16'h0001, "register enable drives");
        oe_reg <= 1'b0;
        // Readout modes over the table rows.
        for (i = 0; i < 7; i++)
        begin
            @(posedge mclk);
            cfg.mode <= rows[i].m;
            wait_fv(1'b1);
            wait_fv(1'b0);
            wait_fv(1'b1);
            wait_fv(1'b0);
            chk(16'(cnt), 16'(rows[i].n), "byte count");
            chk({first_b, last_b}, {rows[i].f, rows[i].l}, "readout order");
        end
        standby <= 1'b1;
        wait_fv(1'b0);
        repeat (600) @(posedge mclk);
        chk(16'({frame_valid, pixel_clk, line_valid}), 16'h0000, "standby stops readout");
        prog_value <= 16'ha55a;
        prog(1'b0);
        prog(1'b1);
        #1;
        chk(16'(prog_busy), 16'h0001, "programming busy");
        for (k = 0; k < 4100 && prog_done !== 1'b1; k++)
            @(posedge mclk);
        chk(16'(k > 3990), 16'h0001, "programming time");
        chk(otp_data, 16'ha55a, "store contents");
        prog(1'b0);
        #1;
        chk(16'(prog_done), 16'h0000, "data write clears done");
        @(posedge mclk);
        oe_pin_en <= 1'b1;
        @(posedge mclk);
        #1;
        chk(16'(pix_oe), 16'h0001, "pin enable low drives");
        @(posedge mclk);
        gpio_in <= 5'h15;
        #1;
        chk(16'(pix_oe), 16'h0000, "asynchronous release");
        @(posedge mclk);
        raw10_en <= 1'b1;
        gpio_dir <= 5'h00;
        repeat (16) @(posedge mclk);
        chk(16'({gpio_oe[1:0], gpio_out[1:0]}), 16'h000c, "raw low bits driven");
        // A flash pulse first, then a shutter pulse, each started by one frame.
        for (i = 0; i < 2; i++)
        begin
            standby <= 1'b0;
            gpio4_func <= (i == 0) ? G4_FLASH : G4_SHUTTER;
            for (k = 0; k < 20000 && gpio_out[4] !== 1'b1; k++)
                @(posedge mclk);
            standby <= 1'b1;
            repeat (((i == 0) ? FLASH_CYC : SHUTTER_CYC) - 12'h014) @(posedge mclk);
            chk(16'(gpio_out[4]), 16'h0001, "strobe pulse held");
            repeat (40) @(posedge mclk);
            chk(16'(gpio_out[4]), 16'h0000, "strobe pulse ended");
        end
        finish_test();
    end
endmodule
